//--- ddr4_dev_model.sv
// Purpose: Device-side monitor for the DDR4 timing host
// Assumes: One device clock per core_clk; command codes last one cycle
// Notes:   Counts spacing faults and flags internal write start; drives nothing back to the host
`timescale 1ns/1ps
module ddr4_dev_model #(
	parameter int MOD_CK  = 4,  // Mode update delay
	parameter int GEAR_CK = 8,  // Larger of reset and self-refresh exit
	parameter int RFC_CK  = 16, // Refresh cycle
	parameter int PL_CK   = 4,  // Parity latency
	parameter int WL_CK   = 9   // Write latency
) (
	input  wire logic       core_clk,  // Device clock
	input  wire logic       arst_n,    // Reset, active low
	input  wire logic       cke,       // Clock enable
	input  wire logic [2:0] cmd,       // Command code
	input  wire logic       dqs,       // Strobe level
	input  wire logic       dqs_oe,    // Strobe drive enable
	input  wire logic       parity_en, // Address parity on
	input  wire logic       dll_off,   // DLL-off mode
	output int              viol_cnt,  // Spacing faults seen
	output logic            wr_start   // Internal write begins
);
	int   cyc_q, cke_t_q, mrs_t_q, sync_t_q, wl_t_q, ref_t_q, wr_q, rfc_need;
	logic cke_q, oe_q, dqs_q, bad;

	// Refresh grows by the parity latency with parity on and DLL off
	assign rfc_need = RFC_CK + ((parity_en && dll_off) ? PL_CK : 0);

	// Faults are judged against stamps of earlier events, so a late stamp can only raise one
	assign bad = (cmd == ddr4_host_pkg::CMD_MRS_GD && cyc_q - cke_t_q < GEAR_CK) ||
		(cmd == ddr4_host_pkg::CMD_SYNC && cyc_q - mrs_t_q < MOD_CK + 4) ||
		(cmd != ddr4_host_pkg::CMD_NOP && cmd != ddr4_host_pkg::CMD_SYNC &&
		 cyc_q - sync_t_q < MOD_CK) ||
		(cmd != ddr4_host_pkg::CMD_NOP && cyc_q - ref_t_q < rfc_need) ||
		(dqs_oe && !oe_q && cyc_q - wl_t_q < 25) ||
		(dqs && !dqs_q && cyc_q - wl_t_q < 40);

	// Event stamps and fault count
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			cyc_q    <= 0;
			viol_cnt <= 0;
			cke_q    <= 1'b0;
			oe_q     <= 1'b0;
			dqs_q    <= 1'b0;
			cke_t_q  <= 0;
			mrs_t_q  <= -1000;
			sync_t_q <= -1000;
			wl_t_q   <= -1000;
			ref_t_q  <= -1000;
		end else begin
			cyc_q    <= cyc_q + 1;
			viol_cnt <= viol_cnt + int'(bad);
			cke_q    <= cke;
			oe_q     <= dqs_oe;
			dqs_q    <= dqs;
			if (cke && !cke_q) cke_t_q <= cyc_q;
			if (cmd == ddr4_host_pkg::CMD_MRS_GD) mrs_t_q <= cyc_q;
			if (cmd == ddr4_host_pkg::CMD_SYNC) sync_t_q <= cyc_q;
			if (cmd == ddr4_host_pkg::CMD_MRS_WL) wl_t_q <= cyc_q;
			if (cmd == ddr4_host_pkg::CMD_REF) ref_t_q <= cyc_q;
		end
	end

	// Internal write start four clocks past write latency; pins cannot show fixed chop-four
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) wr_q <= 0;
		else if (cmd == ddr4_host_pkg::CMD_USER) wr_q <= WL_CK + 4;
		else if (wr_q > 0) wr_q <= wr_q - 1;
	end
	assign wr_start = (wr_q == 1);
endmodule : ddr4_dev_model

//--- ddr4_host_pkg.sv
// Purpose: Shared constants and conversion helpers for the DDR4 timing host
// Assumes: One device clock per core_clk cycle
// Notes:   Counts are device clocks; times are in picoseconds, except CLK_PERIOD_NS in nanoseconds
package ddr4_host_pkg;
	localparam int CNT_W = 16;

	// Termination high time, in clocks
	localparam logic [3:0] TERM_B8_1CK = 4'h6;
	localparam logic [3:0] TERM_B8_2CK = 4'h7;
	localparam logic [3:0] TERM_C4_1CK = 4'h4;
	localparam logic [3:0] TERM_C4_2CK = 4'h5;

	// Write leveling and gear-down spacing, in clocks
	localparam int WRLVL_DRIVE_CK  = 25;
	localparam int WRLVL_STROBE_CK = 40;
	localparam int SYNC_EXTRA_CK   = 4;

	// Command/address latency floor
	localparam int CAL_FLOOR_CK = 3;
	localparam int CAL_TIME_PS  = 3748;

	// Slow-clock handling and rounding
	localparam int SLOW_RATE_MTS = 1600;
	localparam int SLOW_CK_PS    = 1250;
	localparam int RATE_PS_MTS   = 2000000;
	localparam int SPD_ADJ_PM    = 974;
	localparam int PER_MILLE     = 1000;
	localparam int PS_PER_NS     = 1000;
	localparam int CLK_PERIOD_NS = 10;
	localparam int CLK_PERIOD_PS = CLK_PERIOD_NS * PS_PER_NS;

	// Command codes on the device command port
	localparam logic [2:0] CMD_NOP    = 3'h0;
	localparam logic [2:0] CMD_MRS_GD = 3'h1;
	localparam logic [2:0] CMD_REF    = 3'h2;
	localparam logic [2:0] CMD_SYNC   = 3'h3;
	localparam logic [2:0] CMD_USER   = 3'h4;
	localparam logic [2:0] CMD_MRS_WL = 3'h5;

	// Acknowledge bit positions
	localparam int ACK_W   = 5;
	localparam int ACK_GD  = 0;
	localparam int ACK_WL  = 1;
	localparam int ACK_STB = 2;
	localparam int ACK_REF = 3;
	localparam int ACK_CMD = 4;

	// Below the slowest grade, convert times with that grade's period
	function automatic int eff_ck_ps(input int ck_ps);
		int rate;
		rate = RATE_PS_MTS / ck_ps;
		return (rate < SLOW_RATE_MTS) ? SLOW_CK_PS : ck_ps;
	endfunction : eff_ck_ps

	// Presence-data value: truncate after adding the adjustment
	function automatic int spd_nck(input int ps, input int ck_ps);
		return (ps * PER_MILLE + SPD_ADJ_PM * ck_ps) / (PER_MILLE * ck_ps);
	endfunction : spd_nck

	// Other values: round up to whole clocks
	function automatic int nonspd_nck(input int ps, input int ck_ps);
		return (ps + ck_ps - 1) / ck_ps;
	endfunction : nonspd_nck
endpackage : ddr4_host_pkg

//--- ddr4_timing_host.sv
// Purpose: Host-side sequencer that spaces DDR4 commands, termination,
//          write leveling strobes and the gear-down entry
// Assumes: Device clock equals core_clk; requests are levels held to ack
// Notes:   Priority refresh > gear-down > leveling > user command
//
// Summary of operation
// R01: With a burst-eight write, termination stays high 6 clocks (1-clock preamble) or 7 (2-clock).
// R02: Without a write or with chop-four, termination stays high 4 clocks or 5 by preamble mode.
// R03: The first strobe rising edge comes at least 40 clocks after leveling mode is set.
// R04: The strobe pair is driven no sooner than 25 clocks after leveling mode is set.
// R05: The gear-down mode write waits the reset-exit delay after clock enable rises.
// R06: The gear-down enable waits the self-refresh exit delay after clock enable rises.
// R07: The sync pulse follows the gear-down mode write by at least the update delay plus 4.
// R08: The first valid command follows the sync pulse by at least the update delay.
// R09: The device starts its internal write 4 clocks after write latency, or 2 for fixed chop; the device model always uses 4.
// R10: With parity on and DLL off each refresh interval grows by the parity latency.
// R11: The programmed address latency is at least max(3, 3.748 ns over the period).
// R12: Below 1600 MT/s the 1600 grade clock figures are used.
// R13: Row activity is watched so that hammering one row can be flagged.
// R14: Presence-data times convert by truncating ps over period plus 0.974.
// R15: Other times convert by rounding ns over period up.
`timescale 1ns/1ps
module ddr4_timing_host #(
	parameter int ROW_W      = 17,     // Row address width
	parameter int MOD_CK     = 24,     // Mode update delay, clocks
	parameter int XPR_CK     = 64,     // Reset exit delay, clocks
	parameter int XS_CK      = 64,     // Self-refresh exit delay, clocks
	parameter int RFC_PS     = 350000, // Refresh cycle time, presence data
	parameter int PL_CK      = 4,      // Parity latency, clocks
	parameter int CKE_LOW_CK = 16,     // Clock enable low after reset
	parameter int ROW_HOT_N  = 64      // Same-row streak that must be exceeded to flag
) (
	input  wire logic                         core_clk,        // Core and device clock
	input  wire logic                         arst_n,          // Async reset, active low
	input  wire logic                         gd_req,          // Enter gear-down
	input  wire logic                         wl_req,          // Enter write leveling
	input  wire logic                         wl_strobe_req,   // One leveling strobe
	input  wire logic                         wl_exit,         // Leave write leveling
	input  wire logic                         ref_req,         // Refresh
	input  wire logic                         cmd_req,         // User command
	input  wire logic                         cmd_write,       // Command is a write
	input  wire logic                         cmd_chop,        // Write is chop-four
	input  wire logic                         cmd_odt,         // Raise termination
	input  wire logic [ROW_W-1:0]             cmd_row,         // Row of the command
	input  wire logic                         preamble_2ck,    // 2-clock preamble mode
	input  wire logic                         parity_en,       // Address parity on
	input  wire logic                         dll_off,         // DLL-off mode
	output logic [ddr4_host_pkg::ACK_W-1:0]   ack_q,           // One-cycle accept pulses
	output logic                              ready_q,         // Idle, commands accepted
	output logic                              gd_on_q,         // Gear-down entered
	output logic                              row_hot_q,       // Row streak too long
	output logic [3:0]                        cal_q,           // Latency to program
	output logic                              ddr_cke_q,       // Clock enable pin
	output logic                              ddr_odt_q,       // Termination pin
	output logic [2:0]                        ddr_cmd_q,       // Command code
	output logic [ROW_W-1:0]                  ddr_row_q,       // Row address
	output logic                              ddr_dqs_q,       // Strobe level
	output logic                              ddr_dqs_oe_q     // Strobe drive enable
);
	localparam int CW = ddr4_host_pkg::CNT_W;
	localparam int EFF_PS = ddr4_host_pkg::eff_ck_ps(ddr4_host_pkg::CLK_PERIOD_PS); // [R12]
	localparam int RFC_CK = ddr4_host_pkg::spd_nck(RFC_PS, EFF_PS); // [R14]
	localparam int CAL_T  = ddr4_host_pkg::nonspd_nck(ddr4_host_pkg::CAL_TIME_PS, EFF_PS); // [R15]
	localparam int CAL_CK = (CAL_T > ddr4_host_pkg::CAL_FLOOR_CK) ?
	                        CAL_T : ddr4_host_pkg::CAL_FLOOR_CK;
	localparam int GD_WAIT = (XPR_CK > XS_CK) ? XPR_CK : XS_CK;
	localparam logic [CW-1:0] GD_WAIT_C = CW'(GD_WAIT);
	localparam logic [CW-1:0] SYNC_C    = CW'(MOD_CK + ddr4_host_pkg::SYNC_EXTRA_CK);
	localparam logic [CW-1:0] MOD_C     = CW'(MOD_CK);
	localparam logic [CW-1:0] DRIVE_C   = CW'(ddr4_host_pkg::WRLVL_DRIVE_CK);
	localparam logic [CW-1:0] STROBE_C  = CW'(ddr4_host_pkg::WRLVL_STROBE_CK);
	localparam logic [CW-1:0] RFC_C     = CW'(RFC_CK);
	localparam logic [CW-1:0] RFC_PL_C  = CW'(RFC_CK + PL_CK);
	localparam logic [CW-1:0] CKE_C     = CW'(CKE_LOW_CK);
	localparam logic [CW-1:0] HOT_C     = CW'(ROW_HOT_N);
	localparam logic [CW-1:0] ONE_C     = CW'(1);
	localparam logic [CW-1:0] MAX_C     = {CW{1'b1}};

	typedef enum logic [2:0] {
		ST_RESET,
		ST_IDLE,
		ST_GD_SYNC,
		ST_GD_CMD,
		ST_WRLVL,
		ST_REF
	} state_t;

	state_t          state_q;
	logic [CW-1:0]   since_q;      // Clocks since the last spacing event
	logic [CW-1:0]   since_cke_q;  // Clocks since clock enable rose
	logic [CW-1:0]   streak_q;     // Same-row command streak
	logic [3:0]      odt_left_q;   // Termination clocks still owed
	logic [CW-1:0]   rfc_need;
	logic [3:0]      term_need;
	logic            issue_gd, issue_sync, issue_wl, issue_ref, issue_cmd;
	logic            issue_stb, raise_cke, restart;

	// Refresh interval grows when parity and DLL-off combine
	assign rfc_need = (parity_en && dll_off) ? RFC_PL_C : RFC_C; // [R10]

	// Termination length by burst type and preamble mode
	always_comb begin
		if (cmd_write && !cmd_chop) begin
			term_need = preamble_2ck ? ddr4_host_pkg::TERM_B8_2CK :
			                           ddr4_host_pkg::TERM_B8_1CK; // [R01]
		end else begin
			term_need = preamble_2ck ? ddr4_host_pkg::TERM_C4_2CK :
			                           ddr4_host_pkg::TERM_C4_1CK; // [R02]
		end
	end

	// Issue decisions; one per cycle by priority
	assign raise_cke  = (state_q == ST_RESET) && (since_q >= CKE_C);
	assign issue_ref  = (state_q == ST_IDLE) && ref_req;
	assign issue_gd   = (state_q == ST_IDLE) && !ref_req && gd_req && !gd_on_q &&
	                    (since_cke_q >= GD_WAIT_C); // [R05] [R06]
	assign issue_wl   = (state_q == ST_IDLE) && !ref_req && !issue_gd && wl_req;
	assign issue_cmd  = (state_q == ST_IDLE) && !ref_req && !issue_gd && !wl_req &&
	                    cmd_req;
	assign issue_sync = (state_q == ST_GD_SYNC) && (since_q >= SYNC_C); // [R07]
	// Strobe only once the strobe is low, so each pulse is one rising edge
	assign issue_stb  = (state_q == ST_WRLVL) && wl_strobe_req && !ddr_dqs_q &&
	                    !ack_q[ddr4_host_pkg::ACK_STB] && (since_q >= STROBE_C); // [R03]
	assign restart    = raise_cke || issue_ref || issue_gd || issue_wl || issue_sync;

	// Sequencer, command port and acknowledges
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q   <= ST_RESET;
			ddr_cmd_q <= ddr4_host_pkg::CMD_NOP;
			ddr_row_q <= '0;
			ack_q     <= '0;
			ready_q   <= 1'b0;
			gd_on_q   <= 1'b0;
		end else begin
			ddr_cmd_q <= ddr4_host_pkg::CMD_NOP;
			ack_q     <= '0;
			unique case (state_q)
				ST_RESET: begin
					if (raise_cke) begin
						state_q <= ST_IDLE;
					end
				end
				ST_IDLE: begin
					if (issue_ref) begin
						ddr_cmd_q <= ddr4_host_pkg::CMD_REF;
						ack_q[ddr4_host_pkg::ACK_REF] <= 1'b1;
						state_q <= ST_REF;
					end else if (issue_gd) begin
						ddr_cmd_q <= ddr4_host_pkg::CMD_MRS_GD;
						ack_q[ddr4_host_pkg::ACK_GD] <= 1'b1;
						state_q <= ST_GD_SYNC;
					end else if (issue_wl) begin
						ddr_cmd_q <= ddr4_host_pkg::CMD_MRS_WL;
						ack_q[ddr4_host_pkg::ACK_WL] <= 1'b1;
						state_q <= ST_WRLVL;
					end else if (issue_cmd) begin
						ddr_cmd_q <= ddr4_host_pkg::CMD_USER;
						ddr_row_q <= cmd_row;
						ack_q[ddr4_host_pkg::ACK_CMD] <= 1'b1;
					end
				end
				ST_GD_SYNC: begin
					if (issue_sync) begin
						ddr_cmd_q <= ddr4_host_pkg::CMD_SYNC;
						state_q   <= ST_GD_CMD;
					end
				end
				ST_GD_CMD: begin
					if (since_q >= MOD_C) begin // [R08]
						gd_on_q <= 1'b1;
						state_q <= ST_IDLE;
					end
				end
				ST_WRLVL: begin
					if (issue_stb) begin
						ack_q[ddr4_host_pkg::ACK_STB] <= 1'b1;
					end
					if (wl_exit) begin
						state_q <= ST_IDLE;
					end
				end
				ST_REF: begin
					if (since_q >= rfc_need) begin // [R10]
						state_q <= ST_IDLE;
					end
				end
			endcase
			ready_q <= (state_q == ST_IDLE) && !restart;
		end
	end

	// Spacing counter; starts at one on the issue edge so it equals the
	// clock distance to whatever is issued on a later edge
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			since_q <= '0;
		end else if (restart) begin
			since_q <= ONE_C;
		end else if (since_q != MAX_C) begin
			since_q <= since_q + ONE_C;
		end
	end

	// Clock enable and time since it rose
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			ddr_cke_q   <= 1'b0;
			since_cke_q <= '0;
		end else if (raise_cke) begin
			ddr_cke_q   <= 1'b1;
			since_cke_q <= ONE_C;
		end else if (ddr_cke_q && since_cke_q != MAX_C) begin
			since_cke_q <= since_cke_q + ONE_C;
		end
	end

	// Termination: high for term_need clocks; a new command with cmd_odt restarts it
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			ddr_odt_q  <= 1'b0;
			odt_left_q <= '0;
		end else if (issue_cmd && cmd_odt) begin
			ddr_odt_q  <= 1'b1;
			odt_left_q <= term_need - 4'h1; // [R01] [R02]
		end else if (odt_left_q != 4'h0) begin
			odt_left_q <= odt_left_q - 4'h1;
		end else begin
			ddr_odt_q <= 1'b0;
		end
	end

	// Leveling strobe: drive from the drive delay, pulse one clock high
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			ddr_dqs_oe_q <= 1'b0;
			ddr_dqs_q    <= 1'b0;
		end else begin
			ddr_dqs_oe_q <= (state_q == ST_WRLVL) && !wl_exit &&
			                (since_q >= DRIVE_C); // [R04]
			ddr_dqs_q    <= issue_stb; // [R03]
		end
	end

	// Row streak; a hot row is only flagged, spreading is software's job
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			streak_q  <= '0;
			row_hot_q <= 1'b0;
		end else if (issue_cmd) begin
			if (cmd_row == ddr_row_q && streak_q != MAX_C) begin
				streak_q <= streak_q + ONE_C; // [R13]
			end else if (cmd_row != ddr_row_q) begin
				streak_q <= ONE_C;
			end
			row_hot_q <= (cmd_row == ddr_row_q) && (streak_q >= HOT_C); // [R13]
		end
	end

	// Latency setting is fixed by the clock period
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			cal_q <= 4'(CAL_CK);
		end else begin
			cal_q <= 4'(CAL_CK); // [R11]
		end
	end

	// Helper: consecutive termination-high clocks
	logic [3:0] odt_run_q;
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			odt_run_q <= '0;
		end else begin
			odt_run_q <= ddr_odt_q ? odt_run_q + 4'h1 : 4'h0;
		end
	end

	a_term_b8_len: assert property (@(posedge core_clk) disable iff (!arst_n) // [R01]
		issue_cmd && cmd_odt && cmd_write && !cmd_chop && !preamble_2ck
		|=> ddr_odt_q [*6])
		else $error("termination short for burst-eight write");
	a_term_c4_len: assert property (@(posedge core_clk) disable iff (!arst_n) // [R02]
		issue_cmd && cmd_odt && !(cmd_write && !cmd_chop) && preamble_2ck
		|=> ddr_odt_q [*5] ##1 (!ddr_odt_q || ack_q[ddr4_host_pkg::ACK_CMD]))
		else $error("termination length wrong for chop or no write");
	a_term_min_run: assert property (@(posedge core_clk) disable iff (!arst_n) // [R02]
		$fell(ddr_odt_q) |-> odt_run_q >= ddr4_host_pkg::TERM_C4_1CK)
		else $error("termination dropped too soon");
	a_wl_first_strobe: assert property (@(posedge core_clk) disable iff (!arst_n) // [R03]
		$rose(ddr_dqs_q) |-> $past(since_q) >= STROBE_C && state_q == ST_WRLVL)
		else $error("leveling strobe too early");
	a_wl_drive_delay: assert property (@(posedge core_clk) disable iff (!arst_n) // [R04]
		$rose(ddr_dqs_oe_q) |-> $past(since_q) >= DRIVE_C)
		else $error("strobe driven too early");
	a_gd_after_cke: assert property (@(posedge core_clk) disable iff (!arst_n) // [R05]
		ddr_cmd_q == ddr4_host_pkg::CMD_MRS_GD |-> $past(since_cke_q) >= CW'(XPR_CK))
		else $error("gear-down write before reset exit delay");
	a_gd_enable_xs: assert property (@(posedge core_clk) disable iff (!arst_n) // [R06]
		ddr_cmd_q == ddr4_host_pkg::CMD_MRS_GD |-> $past(since_cke_q) >= CW'(XS_CK))
		else $error("gear-down enable before self-refresh exit delay");
	a_gd_sync_space: assert property (@(posedge core_clk) disable iff (!arst_n) // [R07]
		ddr_cmd_q == ddr4_host_pkg::CMD_SYNC |-> $past(since_q) >= SYNC_C)
		else $error("sync pulse too early");
	a_gd_first_cmd: assert property (@(posedge core_clk) disable iff (!arst_n) // [R08]
		$rose(gd_on_q) |-> $past(since_q) >= MOD_C && $past(state_q) == ST_GD_CMD)
		else $error("gear-down finished before the update delay");
	a_ref_parity_ext: assert property (@(posedge core_clk) disable iff (!arst_n) // [R10]
		$past(state_q) == ST_REF && state_q != ST_REF
		|-> $past(since_q) >= $past(rfc_need))
		else $error("refresh interval cut short");
	a_cal_floor: assert property (@(posedge core_clk) disable iff (!arst_n) // [R11]
		cal_q >= 4'(ddr4_host_pkg::CAL_FLOOR_CK))
		else $error("latency below floor");

	c_gd_entry:  cover property (@(posedge core_clk) disable iff (!arst_n) $rose(gd_on_q));
	c_wl_strobe: cover property (@(posedge core_clk) disable iff (!arst_n) $rose(ddr_dqs_q));
	c_ref_ext:   cover property (@(posedge core_clk) disable iff (!arst_n)
		issue_ref && parity_en && dll_off);
	c_term_b8:   cover property (@(posedge core_clk) disable iff (!arst_n)
		issue_cmd && cmd_odt && cmd_write && !cmd_chop && preamble_2ck);
endmodule : ddr4_timing_host

//--- ddr4_timing_host_tb_top.sv
// Purpose: Self-checking bench for the DDR4 timing host
// Assumes: Shortened counts; device clock equals core_clk
// Notes:   Inputs change by NBA at rising edges; outputs are read just after an edge
`timescale 1ns/1ps
module ddr4_timing_host_tb_top;
	// Presence-data refresh at the 1600 grade period of 1250 ps, truncated after +0.974
	localparam int RFC_CK = (20000 * 1000 + 974 * 1250) / (1250 * 1000);
	localparam int MOD    = 4;
	localparam int WLAT   = 9;

	logic        core_clk = 1'b0, arst_n = 1'b0, gd_req = 1'b0, wl_req = 1'b0;
	logic        wl_strobe_req = 1'b0, wl_exit = 1'b0, ref_req = 1'b0, cmd_req = 1'b0;
	logic        cmd_write = 1'b0, cmd_chop = 1'b0, cmd_odt = 1'b0, preamble_2ck = 1'b0;
	logic        parity_en = 1'b0, dll_off = 1'b0;
	logic [16:0] cmd_row = 17'h00000, ddr_row_q;
	logic [4:0]  ack_q;
	logic [3:0]  cal_q;
	logic [2:0]  ddr_cmd_q;
	logic        ready_q, gd_on_q, row_hot_q, ddr_cke_q, ddr_odt_q, ddr_dqs_q, ddr_dqs_oe_q;
	logic        wr_start;
	int          failures = 0, total_checks = 0, viol_cnt;
	logic [2:0]  odt_mode [6] = '{3'h4, 3'h5, 3'h6, 3'h7, 3'h0, 3'h1};
	int          odt_exp [6] = '{6, 7, 4, 5, 4, 5};
	logic [1:0]  ref_mode [3] = '{2'h0, 2'h3, 2'h1};
	int          ref_exp [3] = '{RFC_CK, RFC_CK + 4, RFC_CK};

	ddr4_timing_host #(.MOD_CK(MOD), .XPR_CK(8), .XS_CK(8), .RFC_PS(20000),
		.CKE_LOW_CK(4), .ROW_HOT_N(4)) uut (
		.core_clk(core_clk), .arst_n(arst_n), .gd_req(gd_req), .wl_req(wl_req),
		.wl_strobe_req(wl_strobe_req), .wl_exit(wl_exit), .ref_req(ref_req),
		.cmd_req(cmd_req), .cmd_write(cmd_write), .cmd_chop(cmd_chop), .cmd_odt(cmd_odt),
		.cmd_row(cmd_row), .preamble_2ck(preamble_2ck), .parity_en(parity_en),
		.dll_off(dll_off), .ack_q(ack_q), .ready_q(ready_q), .gd_on_q(gd_on_q),
		.row_hot_q(row_hot_q), .cal_q(cal_q), .ddr_cke_q(ddr_cke_q), .ddr_odt_q(ddr_odt_q),
		.ddr_cmd_q(ddr_cmd_q), .ddr_row_q(ddr_row_q), .ddr_dqs_q(ddr_dqs_q),
		.ddr_dqs_oe_q(ddr_dqs_oe_q));

	ddr4_dev_model #(.MOD_CK(MOD), .RFC_CK(RFC_CK), .WL_CK(WLAT)) dev (
		.core_clk(core_clk), .arst_n(arst_n), .cke(ddr_cke_q), .cmd(ddr_cmd_q),
		.dqs(ddr_dqs_q), .dqs_oe(ddr_dqs_oe_q), .parity_en(parity_en), .dll_off(dll_off),
		.viol_cnt(viol_cnt), .wr_start(wr_start));

	// 100 MHz clock
	always #5 core_clk = ~core_clk;

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask : tick

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : check

	task automatic final_report();
		if (failures == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : final_report

	// Bounded wait for idle, read from the previous edge's outputs
	task automatic wait_ready();
		int n;
		n = 0;
		do begin
			tick(1);
			n++;
		end while (ready_q !== 1'b1 && n < 500);
		check("ready", n < 500, 1'b1);
	endtask : wait_ready

	// Request stays up until its accept pulse shows
	task automatic wait_ack(input int b);
		int n;
		n = 0;
		do begin
			tick(1);
			n++;
		end while (ack_q[b] !== 1'b1 && n < 500);
		check("ack", n < 500, 1'b1);
	endtask : wait_ack

	// One user command, released at the edge that takes it
	task automatic one_cmd(input logic w, c, p, o, input logic [16:0] row);
		wait_ready();
		cmd_req      <= 1'b1;
		cmd_write    <= w;
		cmd_chop     <= c;
		preamble_2ck <= p;
		cmd_odt      <= o;
		cmd_row      <= row;
		tick(1);
		cmd_req <= 1'b0;
		tick(1);
		check("cmd ack", ack_q[ddr4_host_pkg::ACK_CMD], 1'b1);
		check("cmd code", ddr_cmd_q, ddr4_host_pkg::CMD_USER);
		check("cmd row", ddr_row_q, row);
	endtask : one_cmd

	task automatic t_reset();
		arst_n <= 1'b0;
		tick(2);
		check("cal", cal_q, 4'h3);
		check("cke", ddr_cke_q, 1'b0);
		check("ack", ack_q, 5'h00);
		tick(3);
		arst_n <= 1'b1;
	endtask : t_reset

	// Gear-down asked for before idle, then asked again once entered
	task automatic t_gear();
		int   n;
		logic seen;
		gd_req <= 1'b1;
		wait_ack(ddr4_host_pkg::ACK_GD);
		gd_req <= 1'b0;
		check("mrs code", ddr_cmd_q, ddr4_host_pkg::CMD_MRS_GD);
		check("cke up", ddr_cke_q, 1'b1);
		n = 0;
		while (ddr_cmd_q !== ddr4_host_pkg::CMD_SYNC && n < 100) begin tick(1); n++; end
		check("sync gap", n, MOD + 4);
		n = 0;
		while (gd_on_q !== 1'b1 && n < 100) begin tick(1); n++; end
		check("first cmd gap", n >= MOD && n < 100, 1'b1);
		one_cmd(1'b0, 1'b0, 1'b0, 1'b0, 17'h00100);
		gd_req <= 1'b1;
		seen = 1'b0;
		repeat (10) begin tick(1); seen |= ack_q[ddr4_host_pkg::ACK_GD]; end
		gd_req <= 1'b0;
		check("gd refused", seen, 1'b0);
	endtask : t_gear

	task automatic t_odt();
		int n;
		for (int i = 0; i < 6; i++) begin
			one_cmd(odt_mode[i][2], odt_mode[i][1], odt_mode[i][0], 1'b1, 17'(i));
			n = 0;
			while (ddr_odt_q === 1'b1 && n < 20) begin tick(1); n++; end
			check("odt high", n, odt_exp[i]);
		end
	endtask : t_odt

	// Five same-row commands back to back, then another row; the flag needs a streak past four
	task automatic t_row();
		int acks;
		int n;
		acks = 0;
		wait_ready();
		cmd_req <= 1'b1;
		cmd_odt <= 1'b0;
		cmd_row <= 17'h1abcd;
		for (int i = 0; i < 6; i++) begin
			tick(1);
			acks += int'(ack_q[ddr4_host_pkg::ACK_CMD] === 1'b1);
			if (i == 4) cmd_req <= 1'b0;
		end
		check("burst acks", acks, 5);
		tick(1);
		check("row hot", row_hot_q, 1'b1);
		one_cmd(1'b0, 1'b0, 1'b0, 1'b0, 17'h00001);
		tick(1);
		check("row cool", row_hot_q, 1'b0);
		n = 1;
		while (wr_start !== 1'b1 && n < 100) begin tick(1); n++; end
		check("write start", n, WLAT + 4);
	endtask : t_row

	// Strobes are asked for early; the host must hold them back
	task automatic t_wl();
		int   n, pulses;
		logic prev;
		wl_req <= 1'b1;
		wait_ack(ddr4_host_pkg::ACK_WL);
		wl_req <= 1'b0;
		check("wl code", ddr_cmd_q, ddr4_host_pkg::CMD_MRS_WL);
		n = 0;
		while (ddr_dqs_oe_q !== 1'b1 && n < 100) begin tick(1); n++; end
		check("drive gap", n >= 25 && n < 100, 1'b1);
		wl_strobe_req <= 1'b1;
		while (ack_q[ddr4_host_pkg::ACK_STB] !== 1'b1 && n < 200) begin tick(1); n++; end
		check("strobe gap", n >= 40 && n < 200, 1'b1);
		check("strobe level", ddr_dqs_q, 1'b1);
		pulses = 0;
		prev = 1'b1;
		repeat (8) begin
			tick(1);
			check("strobe spacing", prev & ddr_dqs_q, 1'b0);
			prev = ddr_dqs_q;
			pulses += int'(ddr_dqs_q === 1'b1);
		end
		check("strobe count", pulses >= 2, 1'b1);
		wl_strobe_req <= 1'b0;
		wl_exit <= 1'b1;
		tick(1);
		wl_exit <= 1'b0;
		tick(1);
		check("drive off", ddr_dqs_oe_q, 1'b0);
	endtask : t_wl

	// Refresh and a user command raised together; the command waits out the refresh
	task automatic t_ref();
		int n;
		for (int i = 0; i < 3; i++) begin
			wait_ready();
			parity_en <= ref_mode[i][1];
			dll_off   <= ref_mode[i][0];
			ref_req   <= 1'b1;
			cmd_req   <= 1'b1;
			wait_ack(ddr4_host_pkg::ACK_REF);
			ref_req <= 1'b0;
			check("ref code", ddr_cmd_q, ddr4_host_pkg::CMD_REF);
			n = 0;
			while (ack_q[ddr4_host_pkg::ACK_CMD] !== 1'b1 && n < 100) begin tick(1); n++; end
			cmd_req <= 1'b0;
			check("ref gap", n >= ref_exp[i] && n <= ref_exp[i] + 3, 1'b1);
		end
		parity_en <= 1'b0;
		dll_off   <= 1'b0;
	endtask : t_ref

	// Main sequence, with a second reset at the end
	initial begin
		t_reset();
		t_gear();
		t_odt();
		t_row();
		t_wl();
		t_ref();
		tick(30);
		check("cal", cal_q, 4'h3);
		check("device faults", viol_cnt, 0);
		t_reset();
		final_report();
	end

	// Watchdog, well past the few hundred cycles the run needs
	initial begin
		#200000;
		failures++;
		final_report();
	end
endmodule : ddr4_timing_host_tb_top
